// ===== src/rasr_pkg.sv
/*
  Shared constants and types for the reset and address select registers.
  Assumes a byte-wide register access port driven by the serial bus slave.
*/
package rasr_pkg;
  localparam logic [7:0] ADDR_REG_OFS   = 8'h00;
  localparam logic [7:0] RESET_REG_OFS  = 8'h01;
  localparam int         ADDR_SEL_BIT   = 0;
  localparam int         VIDEO_RST_BIT  = 4;
  localparam int         FULL_RST_BIT   = 1;
  localparam int         LOGIC_RST_BIT  = 0;
  localparam logic       ADDR_SEL_RESET = 1'b0;
  localparam logic [2:0] RESET_REG_INIT = 3'h0;
  localparam int         RST_PULSE_CYC  = 4;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rasr_req_t;

  typedef struct packed {
    logic video;
    logic full;
    logic logic_only;
  } rasr_rst_t;
endpackage

// ===== src/rasr_regs.sv
/*
  Device address select register and self-clearing reset control register.
  Assumes the serial bus slave presents one-cycle write strobes with address
  and data, and reads combinationally by address. Strap value is sampled
  outside and held stable.
*/
// Contract
// RULE1: Select bit 0 uses strap address; 1 uses programmable address field.
// RULE2: Writing bit 4 resets video input logic, then clears itself.
// RULE3: Writing bit 1 resets all logic and registers, then self-clears.
// RULE4: Host should then set bridge control bit 1 to restore loaded values.
// RULE5: Writing bit 0 resets logic but keeps general registers, self-clears.
// RULE6: Logic-only reset reloads strap-defaulted registers from the strap.
// RULE7: Logic-only reset also restores the listed registers to defaults.
// RULE8: Host issues resets this way only in the 3.3V signalling mode.
// RULE9: Register zero bits 7:1 hold read-write address defaulting to strap.
// RULE10: Reset bits read 1 only while their reset runs, then clear.
module rasr_regs
  import rasr_pkg::*;
#(
  parameter int PULSE_CYC = RST_PULSE_CYC
)
(
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire rasr_pkg::rasr_req_t req_i,
  output logic [7:0]            rdata_o,
  input  wire logic [6:0]       address_strap_pin_i,
  output logic [6:0]            active_address_o,
  output rasr_pkg::rasr_rst_t   rst_o,
  output logic                  defaults_restore_o
);
  import rasr_pkg::*;

  logic [6:0] dev_addr_reg, dev_addr_next;
  logic       addr_sel_reg, addr_sel_next;
  logic       strap_loaded_reg, strap_loaded_next;
  rasr_rst_t  rst_reg, rst_next;
  logic [2:0] pulse_next;
  logic       wr_addr, wr_rst;

  assign wr_addr = req_i.wr && req_i.addr == ADDR_REG_OFS;
  assign wr_rst  = req_i.wr && req_i.addr == RESET_REG_OFS;

  // Each reset bit holds for PULSE_CYC cycles, then drops by itself.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_rst
      localparam int B = (g == 2) ? VIDEO_RST_BIT
                       : (g == 1) ? FULL_RST_BIT : LOGIC_RST_BIT;
      logic [2:0] cnt_reg;
      logic [2:0] cnt_next;
      always_comb
      begin
        cnt_next = cnt_reg;
        if (wr_rst && req_i.wdata[B])  // [RULE2] [RULE3] [RULE5]
          cnt_next = 3'(PULSE_CYC);
        else if (cnt_reg != 3'h0)      // [RULE10]
          cnt_next = cnt_reg - 3'h1;
      end
      always_ff @(posedge clk_sys_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          cnt_reg <= RESET_REG_INIT;
        else
          cnt_reg <= cnt_next;
      end
      // The bit follows the next count, so it rises right after the strobe.
      assign pulse_next[g] = cnt_next != 3'h0;
    end
  endgenerate

  always_comb
  begin
    rst_next.video      = pulse_next[2];
    rst_next.full       = pulse_next[1];
    rst_next.logic_only = pulse_next[0];
    dev_addr_next     = dev_addr_reg;
    addr_sel_next     = addr_sel_reg;
    strap_loaded_next = 1'b1;
    // The strap is caught after reset release, never under async reset.
    if (!strap_loaded_reg || rst_reg.full || rst_reg.logic_only)
    begin
      dev_addr_next = address_strap_pin_i;                // [RULE6] [RULE9]
      if (rst_reg.full)
        addr_sel_next = ADDR_SEL_RESET;                   // [RULE3]
    end
    else if (wr_addr)
    begin
      dev_addr_next = req_i.wdata[7:1];                   // [RULE9]
      addr_sel_next = req_i.wdata[ADDR_SEL_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dev_addr_reg     <= 7'h00;
      addr_sel_reg     <= ADDR_SEL_RESET;
      strap_loaded_reg <= 1'b0;
      rst_reg          <= '0;
    end
    else
    begin
      dev_addr_reg     <= dev_addr_next;
      addr_sel_reg     <= addr_sel_next;
      strap_loaded_reg <= strap_loaded_next;
      rst_reg          <= rst_next;
    end
  end

  // Strap path is used until software selects the programmable field.
  assign active_address_o = addr_sel_reg ? dev_addr_reg
                                         : address_strap_pin_i; // [RULE1]
  assign rst_o = rst_reg;
  // Listed non-strap registers live elsewhere; they follow this strobe.
  assign defaults_restore_o = rst_reg.logic_only;              // [RULE7]

  always_comb
  begin
    rdata_o = 8'h00;
    if (req_i.addr == ADDR_REG_OFS)
      rdata_o = {dev_addr_reg, addr_sel_reg};
    else if (req_i.addr == RESET_REG_OFS)
    begin
      rdata_o[VIDEO_RST_BIT] = rst_reg.video;                  // [RULE10]
      rdata_o[FULL_RST_BIT]  = rst_reg.full;
      rdata_o[LOGIC_RST_BIT] = rst_reg.logic_only;
    end
  end

  property p_sel_strap;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !addr_sel_reg |-> active_address_o == address_strap_pin_i;
  endproperty
  a_sel_strap: assert property (p_sel_strap) // [RULE1]
    else $error("strap address not used");

  sequence s_wr_video;
    wr_rst && req_i.wdata[VIDEO_RST_BIT];
  endsequence
  property p_video;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      s_wr_video |=> rst_o.video [*4] ##1 !rst_o.video;
  endproperty
  a_video: assert property (p_video) // [RULE2]
    else $error("video reset pulse wrong");

  property p_full;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      wr_rst && req_i.wdata[FULL_RST_BIT] |=> rst_o.full ##4 !rst_o.full;
  endproperty
  a_full: assert property (p_full) // [RULE3]
    else $error("full reset pulse wrong");

  property p_logic;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      wr_rst && req_i.wdata[LOGIC_RST_BIT] |=> rst_o.logic_only [*4];
  endproperty
  a_logic: assert property (p_logic) // [RULE5]
    else $error("logic reset pulse wrong");

  property p_reload;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      rst_o.logic_only |=> dev_addr_reg == $past(address_strap_pin_i);
  endproperty
  a_reload: assert property (p_reload) // [RULE6]
    else $error("strap not reloaded");

  sequence s_wr_logic;
    wr_rst && req_i.wdata[LOGIC_RST_BIT];
  endsequence
  property p_restore;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      s_wr_logic |=> defaults_restore_o;
  endproperty
  a_restore: assert property (p_restore) // [RULE7]
    else $error("defaults strobe mismatch");

  property p_addr_wr;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      wr_addr && strap_loaded_reg && !rst_o.full && !rst_o.logic_only
      |=> dev_addr_reg == $past(req_i.wdata[7:1]);
  endproperty
  a_addr_wr: assert property (p_addr_wr) // [RULE9]
    else $error("address field not written");

  property p_sel_prog;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      wr_addr && strap_loaded_reg && !rst_o.full && !rst_o.logic_only
      && req_i.wdata[ADDR_SEL_BIT]
      |=> active_address_o == $past(req_i.wdata[7:1]);
  endproperty
  a_sel_prog: assert property (p_sel_prog) // [RULE1]
    else $error("programmed address not used");

  property p_strap_load;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !strap_loaded_reg |=> dev_addr_reg == $past(address_strap_pin_i);
  endproperty
  a_strap_load: assert property (p_strap_load) // [RULE9]
    else $error("address field missed strap default");

  property p_full_reload;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      rst_o.full |=> !addr_sel_reg
                     && dev_addr_reg == $past(address_strap_pin_i);
  endproperty
  a_full_reload: assert property (p_full_reload) // [RULE3]
    else $error("full reset left registers set");

  property p_keep_sel;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      rst_o.logic_only && !rst_o.full |=> $stable(addr_sel_reg);
  endproperty
  a_keep_sel: assert property (p_keep_sel) // [RULE5]
    else $error("logic reset changed select bit");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(rst_o.full) |-> !rst_o.full [*2] or wr_rst;
  endproperty
  a_clear: assert property (p_clear) // [RULE10]
    else $error("reset bit did not stay clear");
endmodule

// ===== test/rasr_host.sv
/*
  Behavioural host that writes and reads the registers.
  Assumes the shared system clock; it drives requests at falling edges.
*/
module rasr_host
(
  input  wire logic          clk_sys_i,
  input  wire logic [7:0]    rdata_i,
  output rasr_pkg::rasr_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import rasr_pkg::*;

  // Resets are only issued through the register in 3.3V mode.
  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req_o = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req_o.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    req_o.addr = a;
    #1 d = rdata_i;
  endtask

  // A full reset is followed by setting the bridge control bit.
  task automatic full_reset_followup();
    wr(8'h4F, 8'h02);
  endtask
endmodule

// ===== test/tb_top.sv
/*
  Self-checking bench for the address select and reset registers.
  Assumes a strap value that moves only under power-on reset, and the pulse length from the package.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rasr_pkg::*;

  localparam logic [6:0] STRAP     = 7'h2A;
  localparam logic [6:0] STRAP_ALT = 7'h5C;
  logic [6:0] strap     = STRAP;
  logic       clk_sys_i = 1'b0;
  logic       arst_n_i  = 1'b0;
  rasr_req_t  req;
  logic [7:0] rdata;
  logic [6:0] act;
  rasr_rst_t  rst;
  logic       dflt;
  logic [7:0] rv;
  int         failures  = 0;
  int         cmp_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  rasr_regs #(.PULSE_CYC(RST_PULSE_CYC)) i_dut (
    .clk_sys_i          (clk_sys_i),
    .arst_n_i           (arst_n_i),
    .req_i              (req),
    .rdata_o            (rdata),
    .address_strap_pin_i(strap),
    .active_address_o   (act),
    .rst_o              (rst),
    .defaults_restore_o (dflt)
  );

  rasr_host i_host (
    .clk_sys_i(clk_sys_i),
    .rdata_i  (rdata),
    .req_o    (req)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The bit must drop by itself, so one cycle past the pulse is checked too.
  task automatic pulse(input int k, input int b);
    for (int i = 0; i <= RST_PULSE_CYC; i++)
    begin
      chk({7'h0, rst[k]}, {7'h0, i < RST_PULSE_CYC});
      chk({7'h0, rdata[b]}, {7'h0, i < RST_PULSE_CYC});
      @(negedge clk_sys_i);
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    i_host.rd(ADDR_REG_OFS, rv);
    chk(rv, {STRAP, 1'b0});
    chk({1'b0, act}, {1'b0, STRAP});
    i_host.wr(ADDR_REG_OFS, 8'h6B);
    chk({1'b0, act}, 8'h35);
    i_host.wr(RESET_REG_OFS, 8'h10);
    chk({7'h0, rst.full}, 8'h00);
    pulse(2, VIDEO_RST_BIT);
    i_host.wr(RESET_REG_OFS, 8'h01);
    chk({7'h0, dflt}, 8'h01);
    pulse(0, LOGIC_RST_BIT);
    chk({7'h0, dflt}, 8'h00);
    i_host.rd(ADDR_REG_OFS, rv);
    chk(rv, {STRAP, 1'b1});
    chk({1'b0, act}, {1'b0, STRAP});
    i_host.wr(ADDR_REG_OFS, 8'h6B);
    i_host.wr(RESET_REG_OFS, 8'h02);
    pulse(1, FULL_RST_BIT);
    i_host.rd(ADDR_REG_OFS, rv);
    chk(rv, {STRAP, 1'b0});
    i_host.full_reset_followup();
    i_host.rd(8'h4F, rv);
    chk(rv, 8'h00);
    i_host.wr(RESET_REG_OFS, 8'h01);
    // This address write lands while the logic reset runs and is refused.
    i_host.wr(ADDR_REG_OFS, 8'h6B);
    repeat (RST_PULSE_CYC) @(negedge clk_sys_i);
    i_host.rd(ADDR_REG_OFS, rv);
    chk(rv, {STRAP, 1'b0});
    chk({7'h0, dflt}, 8'h00);
    i_host.wr(RESET_REG_OFS, 8'h13);
    chk({5'h0, rst}, 8'h07);
    // A second power-on reset in mid-pulse, with the strap moved under it.
    arst_n_i = 1'b0;
    strap    = STRAP_ALT;
    #1;
    chk({5'h0, rst}, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    i_host.rd(ADDR_REG_OFS, rv);
    chk(rv, {STRAP_ALT, 1'b0});
    chk({1'b0, act}, {1'b0, STRAP_ALT});
    tally_and_finish();
  end

  initial
  begin
    #20us;
    failures++;
    tally_and_finish();
  end
endmodule
